/* logic/fijs_pkg.sv */
package fijs_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] FIJS_OFS_CTRL = 8'h00;
   localparam logic [7:0] FIJS_OFS_STATUS = 8'h04;
   localparam logic [7:0] FIJS_OFS_MASK = 8'h08;
   localparam logic [7:0] FIJS_OFS_PROBE = 8'h0c;
   localparam logic [7:0] FIJS_OFS_ADDR_LO = 8'h10;
   localparam logic [7:0] FIJS_OFS_ADDR_HI = 8'h14;

   localparam logic [31:0] FIJS_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] FIJS_MASK_RST = 32'h0000_0000;
   localparam logic [31:0] FIJS_STATUS_RST = 32'h0000_0000;

   // status and mask bit positions
   localparam int FIJS_EV_INSERT = 0;
   localparam int FIJS_EV_BADPULSE = 1;
   localparam int FIJS_EV_W = 2;

   // ----------------------------------------------------------------
   // probe layout
   // ----------------------------------------------------------------
   localparam int FIJS_PIN_W = 9;
   localparam int FIJS_POUT_W = 41;
   localparam int FIJS_NEW_PIN_W = 8;
   localparam int FIJS_OLD_PIN_W = 9;
   localparam int FIJS_NEW_POUT_W = 41;
   localparam int FIJS_OLD_POUT_W = 37;
   localparam int FIJS_NEW_STRB_BIT = 40;
   localparam int FIJS_OLD_STRB_BIT = 36;
   localparam int FIJS_NEW_ADDR_W = 40;
   localparam int FIJS_OLD_ADDR_W = 36;
   localparam int FIJS_RSVD_BIT = 8;
   localparam int FIJS_HB_BIT = 7;
   localparam int FIJS_UNC_BIT = 6;
   localparam int FIJS_CRIT_BIT = 5;
   localparam int FIJS_INJ_BIT = 4;
   localparam int FIJS_NEW_CLS_BIT = 3;
   localparam int FIJS_OLD_CLS_BIT = 2;
   localparam int FIJS_OBS_BIT = 1;
   localparam int FIJS_INIT_BIT = 0;

   // host pulse length in clock cycles
   localparam logic [2:0] FIJS_PULSE_CYC = 3'h3;

   localparam logic [1:0] FIJS_RESP_OKAY = 2'h0;
   localparam logic [1:0] FIJS_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic heartbeat;
      logic uncorrectable;
      logic critical;
      logic insertion;
      logic classification;
      logic observation;
      logic initialization;
   } fijs_flags_t;

   typedef struct packed {
      logic [28:0] rsvd;
      logic retrieval;
      logic older;
      logic jtag;
   } fijs_ctrl_t;

endpackage

/* logic/fijs_sync.sv */
`timescale 1ns/1ps
module fijs_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_r <= '0;
         q <= '0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

/* logic/fijs_host_fault_shim.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - two insertion sources: pins or debug probe
// - spi flash retrieval shim only when needed
// - newer: 8-bit input, 41-bit output probe
// - older: 9-bit input, bit8 low, 37-bit output
module fijs_host_fault_shim #(
   parameter int AW = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // controller status flags
   input wire fijs_pkg::fijs_flags_t ctl_flags,
   // physical insertion pins
   input wire logic pin_inject_strobe,
   input wire logic [fijs_pkg::FIJS_NEW_ADDR_W-1:0] pin_inject_address,
   // debug core probes
   input wire logic [fijs_pkg::FIJS_POUT_W-1:0] probe_out,
   output logic [fijs_pkg::FIJS_PIN_W-1:0] probe_in,
   // controller insertion interface
   output logic inject_strobe,
   output logic [fijs_pkg::FIJS_NEW_ADDR_W-1:0] inject_address,
   // retrieval shim enable and interrupt
   output logic retrieval_shim_en,
   output logic irq
);
   import fijs_pkg::*;

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic [FIJS_PIN_W-1:0] pack_probe(input fijs_flags_t f,
                                                         input logic older);
      logic [FIJS_PIN_W-1:0] p;
      p = '0;
      p[FIJS_HB_BIT] = f.heartbeat;
      p[FIJS_UNC_BIT] = f.uncorrectable;
      p[FIJS_CRIT_BIT] = f.critical;
      p[FIJS_INJ_BIT] = f.insertion;
      if (older)
         p[FIJS_OLD_CLS_BIT] = f.classification;
      else
         p[FIJS_NEW_CLS_BIT] = f.classification;
      p[FIJS_OBS_BIT] = f.observation;
      p[FIJS_INIT_BIT] = f.initialization;
      p[FIJS_RSVD_BIT] = 1'b0;
      pack_probe = p;
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   fijs_ctrl_t ctrl_r;
   logic [FIJS_EV_W-1:0] status_r, mask_r, ev_set, st_clr;
   logic aw_got_r, w_got_r, wr_fire;
   logic [AW-1:0] awaddr_r;
   logic [31:0] wdata_r, wmask_r, rd_val;
   logic [FIJS_NEW_ADDR_W-1:0] last_addr_r;

   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         aw_got_r <= 1'b0;
         awaddr_r <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         s_axi_awready <= 1'b0;
         aw_got_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
      else if (s_axi_bvalid && s_axi_bready)
         aw_got_r <= 1'b0;
      else if (!aw_got_r && !s_axi_bvalid)
         s_axi_awready <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_wready <= 1'b0;
         w_got_r <= 1'b0;
         wdata_r <= '0;
         wmask_r <= '0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         s_axi_wready <= 1'b0;
         w_got_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wmask_r <= strb_mask(s_axi_wstrb);
      end
      else if (s_axi_bvalid && s_axi_bready)
         w_got_r <= 1'b0;
      else if (!w_got_r && !s_axi_bvalid)
         s_axi_wready <= 1'b1;
   end

   // write response and register updates
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= FIJS_RESP_OKAY;
         ctrl_r <= FIJS_CTRL_RST;
         mask_r <= FIJS_MASK_RST[FIJS_EV_W-1:0];
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= FIJS_RESP_OKAY;
         unique case (awaddr_r[7:0])
            FIJS_OFS_CTRL: ctrl_r <= (ctrl_r & ~wmask_r) | (wdata_r & wmask_r);
            FIJS_OFS_MASK: mask_r <= (mask_r & ~wmask_r[FIJS_EV_W-1:0])
                                     | (wdata_r[FIJS_EV_W-1:0] & wmask_r[FIJS_EV_W-1:0]);
            FIJS_OFS_STATUS, FIJS_OFS_PROBE, FIJS_OFS_ADDR_LO, FIJS_OFS_ADDR_HI: ;
            default: s_axi_bresp <= FIJS_RESP_SLVERR;
         endcase
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   assign st_clr = (wr_fire && awaddr_r[7:0] == FIJS_OFS_STATUS)
                   ? (wdata_r[FIJS_EV_W-1:0] & wmask_r[FIJS_EV_W-1:0]) : '0;

   // sticky status, set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_r <= FIJS_STATUS_RST[FIJS_EV_W-1:0];
      else
         status_r <= (status_r & ~st_clr) | ev_set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(((status_r & ~st_clr) | ev_set) & mask_r);
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_val = '0;
      unique case (s_axi_araddr[7:0])
         FIJS_OFS_CTRL: rd_val = ctrl_r;
         FIJS_OFS_STATUS: rd_val[FIJS_EV_W-1:0] = status_r;
         FIJS_OFS_MASK: rd_val[FIJS_EV_W-1:0] = mask_r;
         FIJS_OFS_PROBE: rd_val[FIJS_PIN_W-1:0] = probe_in;
         FIJS_OFS_ADDR_LO: rd_val = last_addr_r[31:0];
         FIJS_OFS_ADDR_HI: rd_val[FIJS_NEW_ADDR_W-33:0] = last_addr_r[FIJS_NEW_ADDR_W-1:32];
         default: rd_val = '0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= FIJS_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         unique case (s_axi_araddr[7:0])
            FIJS_OFS_CTRL, FIJS_OFS_STATUS, FIJS_OFS_MASK, FIJS_OFS_PROBE,
            FIJS_OFS_ADDR_LO, FIJS_OFS_ADDR_HI: s_axi_rresp <= FIJS_RESP_OKAY;
            default: s_axi_rresp <= FIJS_RESP_SLVERR;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   // ----------------------------------------------------------------
   // insertion source select
   // ----------------------------------------------------------------
   logic pin_strb_s;
   logic [FIJS_NEW_ADDR_W-1:0] pin_addr_s, addr_sel;
   logic strb_sel, strb_d_r, sel_rise, bad_ev;
   logic [2:0] pw_cnt_r;

   fijs_sync #(.W(FIJS_NEW_ADDR_W + 1)) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({pin_inject_strobe, pin_inject_address}),
      .q({pin_strb_s, pin_addr_s})
   );

   always_comb
   begin
      if (!ctrl_r.jtag)
      begin
         strb_sel = pin_strb_s;
         addr_sel = pin_addr_s;
      end
      else if (ctrl_r.older)
      begin
         strb_sel = probe_out[FIJS_OLD_STRB_BIT];
         addr_sel = {{(FIJS_NEW_ADDR_W - FIJS_OLD_ADDR_W){1'b0}},
                     probe_out[FIJS_OLD_ADDR_W-1:0]};
      end
      else
      begin
         strb_sel = probe_out[FIJS_NEW_STRB_BIT];
         addr_sel = probe_out[FIJS_NEW_ADDR_W-1:0];
      end
   end

   // long host pulse becomes one controller strobe
   assign sel_rise = strb_sel && !strb_d_r;
   assign bad_ev = !strb_sel && strb_d_r && ctrl_r.jtag && pw_cnt_r != FIJS_PULSE_CYC;
   assign ev_set = {bad_ev, sel_rise};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         strb_d_r <= 1'b0;
         pw_cnt_r <= '0;
      end
      else
      begin
         strb_d_r <= strb_sel;
         if (sel_rise)
            pw_cnt_r <= 3'h1;
         else if (strb_sel && pw_cnt_r != 3'h7)
            pw_cnt_r <= pw_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         inject_strobe <= 1'b0;
         inject_address <= '0;
         last_addr_r <= '0;
      end
      else
      begin
         inject_strobe <= sel_rise;
         if (sel_rise)
         begin
            inject_address <= addr_sel;
            last_addr_r <= addr_sel;
         end
      end
   end

   // ----------------------------------------------------------------
   // status probe and retrieval enable
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         probe_in <= '0;
         retrieval_shim_en <= 1'b0;
      end
      else
      begin
         probe_in <= pack_probe(ctl_flags, ctrl_r.older);
         retrieval_shim_en <= ctrl_r.retrieval;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_strobe_on_rise: assert property (sel_rise |=> inject_strobe)
      else $error("no strobe after source rise");
   a_strobe_no_cause: assert property (!sel_rise |=> !inject_strobe)
      else $error("strobe without source rise");
   a_strobe_single: assert property (strb_sel [*3] |-> !inject_strobe)
      else $error("strobe longer than one cycle");
   a_new_addr_map: assert property (sel_rise && ctrl_r.jtag && !ctrl_r.older
      |=> inject_address == $past(probe_out[FIJS_NEW_ADDR_W-1:0]))
      else $error("newer address not from probe 39:0");
   a_old_addr_map: assert property (sel_rise && ctrl_r.jtag && ctrl_r.older
      |=> inject_address[FIJS_OLD_ADDR_W-1:0] == $past(probe_out[FIJS_OLD_ADDR_W-1:0])
          && inject_address[FIJS_NEW_ADDR_W-1:FIJS_OLD_ADDR_W] == '0)
      else $error("older address not from probe 35:0");
   a_new_probe_map: assert property (!ctrl_r.older
      |=> probe_in[FIJS_RSVD_BIT] == 1'b0
      && probe_in[FIJS_NEW_CLS_BIT] == $past(ctl_flags.classification)
      && probe_in[FIJS_HB_BIT] == $past(ctl_flags.heartbeat))
      else $error("newer input probe layout wrong");
   a_old_probe_map: assert property (ctrl_r.older
      |=> probe_in[FIJS_RSVD_BIT] == 1'b0
      && probe_in[FIJS_NEW_CLS_BIT] == 1'b0
      && probe_in[FIJS_OLD_CLS_BIT] == $past(ctl_flags.classification))
      else $error("older input probe layout wrong");
   a_init_obs_bits: assert property (!ctrl_r.older
      |=> probe_in[FIJS_OLD_CLS_BIT] == 1'b0
      && probe_in[FIJS_INIT_BIT] == $past(ctl_flags.initialization)
      && probe_in[FIJS_OBS_BIT] == $past(ctl_flags.observation))
      else $error("init or obs bit misplaced");
   a_retrieval_follow: assert property (##1 retrieval_shim_en == $past(ctrl_r.retrieval))
      else $error("retrieval enable not following control");
   a_bad_pulse_flag: assert property (ctrl_r.jtag && sel_rise ##1 strb_sel
      ##1 !strb_sel |=> status_r[FIJS_EV_BADPULSE])
      else $error("short pulse not flagged");

   c_probe_insert: cover property (ctrl_r.jtag && sel_rise ##3 !strb_sel);
   c_pin_insert: cover property (!ctrl_r.jtag && sel_rise);
   c_bad_pulse: cover property (bad_ev);
   c_irq_raised: cover property (!irq ##1 irq);
endmodule

/* sim/fijs_dbg_host.sv */
`timescale 1ns/1ps
module fijs_dbg_host (
   // clock
   input wire logic aclk,
   // output probe
   output logic [fijs_pkg::FIJS_POUT_W-1:0] probe_out
);
   import fijs_pkg::*;
   initial probe_out = '0;
   // ----------
   // insertion pulse, strobe held len cycles
   // ----------
   task automatic pulse(input logic old, input logic [39:0] a, input int len);
      begin
         @(posedge aclk);
         probe_out <= old ? {a[39:36], 1'b1, a[35:0]} : {1'b1, a};
         repeat (len) @(posedge aclk);
         probe_out <= '0;
      end
   endtask
endmodule

/* sim/tb_fault_insert_jtag_shim.sv */
`timescale 1ns/1ps
module tb_fault_insert_jtag_shim;
   import fijs_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pin_inject_strobe = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [39:0] pin_inject_address = '0;
   fijs_flags_t ctl_flags = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic inject_strobe, retrieval_shim_en, irq;
   logic [31:0] s_axi_rdata, rd, sts = '0, msk = '0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [39:0] inject_address, a;
   logic [40:0] probe_out;
   logic [8:0] probe_in;
   int fail_count = 0, total_checks = 0, seed = 32'h14a4ff86;

   always #10 aclk = ~aclk;

   fijs_host_fault_shim #(.AW(8)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .ctl_flags(ctl_flags),
      .pin_inject_strobe(pin_inject_strobe), .pin_inject_address(pin_inject_address),
      .probe_out(probe_out), .probe_in(probe_in), .inject_strobe(inject_strobe),
      .inject_address(inject_address), .retrieval_shim_en(retrieval_shim_en), .irq(irq)
   );
   fijs_dbg_host host (.aclk(aclk), .probe_out(probe_out));

   // ----------
   // checking and bus tasks
   // ----------
   task automatic finish_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, fail_count);
         if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      begin
         total_checks++;
         if (got !== exp)
         begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   function automatic logic [8:0] pmap(input logic [6:0] f, input logic old);
      pmap = {1'b0, f[6:3], old ? 1'b0 : f[2], old ? f[2] : 1'b0, f[1:0]};
   endfunction

   task automatic axi(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      logic aw_h, w_h, ar_h, dn;
      begin
         @(posedge aclk);
         if (wr)
         begin
            s_axi_awaddr <= ad;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
         end
         else
         begin
            s_axi_araddr <= ad;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
         end
         dn = 1'b0;
         for (int n = 0; n < 40 && !dn; n++)
         begin
            @(negedge aclk);
            aw_h = s_axi_awvalid & s_axi_awready;
            w_h = s_axi_wvalid & s_axi_wready;
            ar_h = s_axi_arvalid & s_axi_arready;
            dn = wr ? (s_axi_bvalid === 1'b1) : (s_axi_rvalid === 1'b1);
            rd = s_axi_rdata;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (aw_h)
               s_axi_awvalid <= 1'b0;
            if (w_h)
               s_axi_wvalid <= 1'b0;
            if (ar_h)
               s_axi_arvalid <= 1'b0;
            if (dn)
               {s_axi_bready, s_axi_rready} <= 2'h0;
         end
         if (!dn)
         begin
            fail_count++;
            finish_test();
         end
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      begin
         axi(1'b1, ad, d);
         chk(rs, ad > FIJS_OFS_ADDR_HI ? FIJS_RESP_SLVERR : FIJS_RESP_OKAY);
         if (ad == FIJS_OFS_STATUS)
            sts = sts & ~d;
         if (ad == FIJS_OFS_MASK)
            msk = d;
         @(negedge aclk);
         chk(irq, |(sts & msk));
      end
   endtask

   task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
      begin
         axi(1'b0, ad, 32'h0);
         chk(rs, ad > FIJS_OFS_ADDR_HI ? FIJS_RESP_SLVERR : FIJS_RESP_OKAY);
         if (rs === FIJS_RESP_OKAY)
            chk(rd, e);
      end
   endtask

   task automatic pins(input logic [39:0] p);
      begin
         @(posedge aclk);
         pin_inject_strobe <= 1'b1;
         pin_inject_address <= p;
         repeat (3) @(posedge aclk);
         pin_inject_strobe <= 1'b0;
      end
   endtask

   task automatic inj(input logic want, input logic [39:0] e);
      logic hit;
      begin
         hit = 1'b0;
         for (int n = 0; n < 10 && !hit; n++)
         begin
            @(negedge aclk);
            hit = (inject_strobe === 1'b1);
         end
         chk(hit, want);
         if (want && !hit)
            finish_test();
         if (hit)
         begin
            chk(inject_address, e);
            @(negedge aclk);
            chk(inject_strobe, 1'b0);
         end
      end
   endtask

   task automatic ins(input int src, input logic [39:0] p, input int len, input logic want,
                      input logic [39:0] e);
      begin
         fork
            if (src == 0) pins(p); else host.pulse(src == 2, p, len);
            inj(want, e);
         join
         if (want)
            sts[0] = 1'b1;
         if (want && src != 0 && len != 3)
            sts[1] = 1'b1;
      end
   endtask

   // ----------
   // main sequence
   // ----------
   initial
   begin
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk({irq, retrieval_shim_en, inject_strobe, probe_in}, 12'h0);
      @(posedge aclk);
      aresetn <= 1'b1;
      rchk(FIJS_OFS_CTRL, FIJS_CTRL_RST);
      rchk(FIJS_OFS_STATUS, FIJS_STATUS_RST);
      rchk(FIJS_OFS_MASK, FIJS_MASK_RST);
      rchk(8'h18, 32'h0);
      wr(8'h1c, 32'hffffffff);
      wr(FIJS_OFS_ADDR_LO, 32'hffffffff);
      rchk(FIJS_OFS_ADDR_LO, 32'h0);
      @(posedge aclk);
      s_axi_wstrb <= 4'h8;
      wr(FIJS_OFS_CTRL, 32'ha5a5a5a5);
      rchk(FIJS_OFS_CTRL, 32'ha500_0000);
      @(posedge aclk);
      s_axi_wstrb <= 4'hf;
      $display("test reset finished");
      for (int i = 1; i >= 0; i--)
      begin
         wr(FIJS_OFS_CTRL, 32'(i * 4));
         chk(retrieval_shim_en, i[0]);
      end
      $display("test retrieval finished");
      a = {8'($random(seed)), 32'($random(seed))};
      ins(1, a, 3, 1'b0, a);
      ins(0, a, 3, 1'b1, a);
      wr(FIJS_OFS_CTRL, 32'h1);
      ins(0, ~a, 3, 1'b0, a);
      $display("test source finished");
      repeat (3)
      begin
         a = {8'($random(seed)), 32'($random(seed))};
         ins(1, a, 3, 1'b1, a);
         rchk(FIJS_OFS_ADDR_LO, a[31:0]);
         rchk(FIJS_OFS_ADDR_HI, {24'h0, a[39:32]});
      end
      rchk(FIJS_OFS_STATUS, sts);
      wr(FIJS_OFS_MASK, 32'h3);
      wr(FIJS_OFS_STATUS, 32'h1);
      for (int l = 2; l <= 4; l += 2)
      begin
         ins(1, a, l, 1'b1, a);
         rchk(FIJS_OFS_STATUS, sts);
         wr(FIJS_OFS_STATUS, sts);
      end
      $display("test newer finished");
      wr(FIJS_OFS_CTRL, 32'h3);
      repeat (2)
      begin
         a = {8'($random(seed)), 32'($random(seed))};
         ins(2, a, 3, 1'b1, {4'h0, a[35:0]});
         rchk(FIJS_OFS_ADDR_HI, {28'h0, a[35:32]});
      end
      $display("test older finished");
      for (int m = 1; m <= 3; m += 2)
      begin
         wr(FIJS_OFS_CTRL, 32'(m));
         repeat (6)
         begin
            @(posedge aclk);
            ctl_flags <= fijs_flags_t'(7'($random(seed)));
            @(posedge aclk);
            @(negedge aclk);
            chk(probe_in, pmap(ctl_flags, m[1]));
         end
         rchk(FIJS_OFS_PROBE, {23'h0, pmap(ctl_flags, m[1])});
      end
      $display("test probe map finished");
      finish_test();
   end
endmodule
